// ===== hdl/mss_defines.vh
/*
  Constants of the motor start-up sequencer: register offsets, field
  positions, AXI response codes, state codes and timing counts.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// Register byte offsets
`define MSS_OFS_CTRL        8'h00
`define MSS_OFS_MCB         8'h04
`define MSS_OFS_MCB_S       8'h08
`define MSS_OFS_PARK        8'h0C
`define MSS_OFS_PRECHG      8'h10
`define MSS_OFS_SPEED       8'h14
`define MSS_OFS_VF          8'h18
`define MSS_OFS_KTORQ       8'h1C
`define MSS_OFS_CLOSED_LOOP_SWITCH_THRESHOLD       8'h20
`define MSS_OFS_STATUS      8'h24
`define MSS_OFS_OFFSET      8'h28
`define MSS_OFS_FEEDBACK    8'h2C
`define MSS_OFS_ANGLE       8'h30

// Field positions
`define MSS_CTRL_START      0
`define MSS_CTRL_DIR        1
`define MSS_MCB_DIAG_LO     0
`define MSS_MCB_DIAG_HI     1
`define MSS_MCBS_SKIP_CAL   6
`define MSS_DIAG_PARK       2'h1
`define MSS_DIAG_VF         2'h2

// Timing: one park count is 1/64 s, 255 counts is about 4 s
`define MSS_CLK_HZ          250000000
`define MSS_PARK_DIV        64
`define MSS_PARK_TICK       (`MSS_CLK_HZ / `MSS_PARK_DIV)
`define MSS_CAL_SAMPLES     13'h1000
`define MSS_CAL_SHIFT       12

// States
`define MSS_ST_IDLE         3'h0
`define MSS_ST_CAL          3'h1
`define MSS_ST_PRECHG       3'h2
`define MSS_ST_PARK         3'h3
`define MSS_ST_OPEN         3'h4
`define MSS_ST_CLOSED       3'h5
`define MSS_ST_VF           3'h6
`define MSS_ST_FAIL         3'h7

// AXI responses
`define MSS_RESP_OKAY       2'h0
`define MSS_RESP_SLVERR     2'h2

`endif

// ===== hdl/mss_motor_startup_sequencer.v
/*
  Motor start-up sequencer: calibration, bootstrap pre-charge, parking,
  open-loop and closed-loop angle estimation, park and V/Hz diagnostics.
  Assumes AXI4-Lite master on sys_clk, feedback inputs from the ADC
  domain (synchronised here) and a PWM stage that reads the outputs.
*/
`timescale 1ns/1ps
`include "mss_defines.vh"

module mss_motor_startup_sequencer (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // AXI4-Lite write address, data and response
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Current feedback and bus voltage from the converter
  input  wire [11:0] phase_v_current_feedback,
  input  wire [11:0] phase_w_current_feedback,
  input  wire [11:0] filtered_bus_voltage,
  // Drive command to the power stage, calibration offsets and corrected feedback
  output reg         drive_enable,
  output reg  [2:0]  low_side_on,
  output reg  [15:0] drive_angle,
  output reg  [15:0] drive_magnitude,
  output reg         current_regulated,
  output reg  [11:0] offset_v,
  output reg  [11:0] offset_w,
  output reg  [11:0] corrected_v,
  output reg  [11:0] corrected_w
);

  // Software registers
  reg [1:0]  sequencer_control;
  reg [7:0]  motor_control_bits;
  reg [7:0]  secondary_motor_control_bits;
  reg [7:0]  park_angle_first;
  reg [7:0]  park_angle_final;
  reg [7:0]  park_current_level;
  reg [7:0]  park_duration;
  reg [7:0]  precharge_pulse_width;
  reg [7:0]  precharge_pulse_delay;
  reg [15:0] precharge_total_time;
  reg [15:0] speed_setpoint;
  reg [15:0] volts_per_hertz_gain;
  reg [15:0] open_loop_torque_gain;
  reg [15:0] closed_loop_switch_threshold;
  reg [15:0] fail_speed_limit;
  reg        start_failure_flag;

  // Sequencer state
  reg [2:0]  state;
  reg [12:0] cal_count;
  reg [23:0] acc_v;
  reg [23:0] acc_w;
  reg [23:0] tick;
  reg [9:0]  park_count;
  reg [15:0] pc_total;
  reg [7:0]  pc_step;
  reg [1:0]  pc_leg;
  reg        pc_on;
  reg [31:0] est_freq;
  reg [15:0] angle_acc;
  reg [15:0] emf_freq;
  reg [23:0] fail_timer;
  reg        start_q;

  // Two-stage synchronisers for converter inputs
  reg [35:0] fb_meta;
  reg [35:0] fb_sync;
  wire [11:0] fb_v   = fb_sync[11:0];
  wire [11:0] fb_w   = fb_sync[23:12];
  wire [11:0] fb_bus = fb_sync[35:24];

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fb_meta <= 36'h0;
      fb_sync <= 36'h0;
    end else begin
      fb_meta <= {filtered_bus_voltage, phase_w_current_feedback, phase_v_current_feedback};
      fb_sync <= fb_meta;
    end
  end

  wire run_req  = sequencer_control[`MSS_CTRL_START];
  wire [1:0] diag = motor_control_bits[`MSS_MCB_DIAG_HI:`MSS_MCB_DIAG_LO];
  wire start_edge = run_req & ~start_q;
  wire [9:0] park_total = {park_duration, 2'h0};
  wire [9:0] park_quarter = {2'h0, park_duration};
  // Calibration sums including the current sample, so all 4096 count
  wire [23:0] cal_sum_v = acc_v + {12'h0, fb_v};
  wire [23:0] cal_sum_w = acc_w + {12'h0, fb_w};
  // V/Hz product; the upper half is the voltage command
  wire [31:0] vf_product = volts_per_hertz_gain * emf_freq;

  // AXI write channel: take address and data in either order
  reg [7:0]  aw_addr;
  reg        aw_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        w_held;
  wire       wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] wd = w_data;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MSS_RESP_OKAY;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `MSS_OFS_CLOSED_LOOP_SWITCH_THRESHOLD + 8'h04) ? `MSS_RESP_SLVERR
                                                          : `MSS_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; settings are sampled live, so stopped edits apply at next start
  // live settings
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sequencer_control            <= 2'h0;
      motor_control_bits           <= 8'h00;
      secondary_motor_control_bits <= 8'h00;
      park_angle_first             <= 8'h00;
      park_angle_final             <= 8'h00;
      park_current_level           <= 8'h00;
      park_duration                <= 8'h00;
      precharge_pulse_width        <= 8'h00;
      precharge_pulse_delay        <= 8'h00;
      precharge_total_time         <= 16'h0000;
      speed_setpoint               <= 16'h0000;
      volts_per_hertz_gain         <= 16'h0000;
      open_loop_torque_gain        <= 16'h0000;
      closed_loop_switch_threshold <= 16'h0000;
      fail_speed_limit             <= 16'h0000;
    end else if (wr_fire & w_strb[0]) begin
      case (aw_addr)
        `MSS_OFS_CTRL:   sequencer_control <= wd[1:0];
        `MSS_OFS_MCB:    motor_control_bits <= wd[7:0];
        `MSS_OFS_MCB_S:  secondary_motor_control_bits <= wd[7:0];
        `MSS_OFS_PARK: begin
          park_angle_first   <= wd[7:0];
          park_angle_final   <= wd[15:8];
          park_current_level <= wd[23:16];
          park_duration      <= wd[31:24];
        end
        `MSS_OFS_PRECHG: begin
          precharge_pulse_width <= wd[7:0];
          precharge_pulse_delay <= wd[15:8];
          precharge_total_time  <= wd[31:16];
        end
        `MSS_OFS_SPEED:  speed_setpoint <= wd[15:0];
        `MSS_OFS_VF:     volts_per_hertz_gain <= wd[15:0];
        `MSS_OFS_KTORQ:  open_loop_torque_gain <= wd[15:0];
        `MSS_OFS_CLOSED_LOOP_SWITCH_THRESHOLD: begin
          closed_loop_switch_threshold <= wd[15:0];
          fail_speed_limit             <= wd[31:16];
        end
        default: ;
      endcase
    end
  end

  // AXI read channel, one read at a time
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `MSS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `MSS_RESP_OKAY;
        case (s_axi_araddr)
          `MSS_OFS_CTRL:     s_axi_rdata <= {30'h0, sequencer_control};
          `MSS_OFS_MCB:      s_axi_rdata <= {24'h0, motor_control_bits};
          `MSS_OFS_MCB_S:    s_axi_rdata <= {24'h0, secondary_motor_control_bits};
          `MSS_OFS_PARK:     s_axi_rdata <= {park_duration, park_current_level,
                                             park_angle_final, park_angle_first};
          `MSS_OFS_PRECHG:   s_axi_rdata <= {precharge_total_time, precharge_pulse_delay,
                                             precharge_pulse_width};
          `MSS_OFS_SPEED:    s_axi_rdata <= {16'h0, speed_setpoint};
          `MSS_OFS_VF:       s_axi_rdata <= {16'h0, volts_per_hertz_gain};
          `MSS_OFS_KTORQ:    s_axi_rdata <= {16'h0, open_loop_torque_gain};
          `MSS_OFS_CLOSED_LOOP_SWITCH_THRESHOLD:    s_axi_rdata <= {fail_speed_limit, closed_loop_switch_threshold};
          `MSS_OFS_STATUS:   s_axi_rdata <= {27'h0, start_failure_flag, 1'b0, state};
          `MSS_OFS_OFFSET:   s_axi_rdata <= {4'h0, offset_w, 4'h0, offset_v};
          `MSS_OFS_FEEDBACK: s_axi_rdata <= {4'h0, corrected_w, 4'h0, corrected_v};
          `MSS_OFS_ANGLE:    s_axi_rdata <= {est_freq[31:16], drive_angle};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `MSS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Offset-corrected feedback
  // subtract offset
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      corrected_v <= 12'h000;
      corrected_w <= 12'h000;
    end else begin
      corrected_v <= fb_v - offset_v;
      corrected_w <= fb_w - offset_w;
    end
  end

  // Start-up sequencer
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state              <= `MSS_ST_IDLE;
      start_q            <= 1'b0;
      cal_count          <= 13'h0;
      acc_v              <= 24'h0;
      acc_w              <= 24'h0;
      offset_v           <= 12'h000;
      offset_w           <= 12'h000;
      tick               <= 24'h0;
      park_count         <= 10'h0;
      pc_total           <= 16'h0;
      pc_step            <= 8'h00;
      pc_leg             <= 2'h0;
      pc_on              <= 1'b0;
      est_freq           <= 32'h0;
      angle_acc          <= 16'h0;
      emf_freq           <= 16'h0;
      fail_timer         <= 24'h0;
      start_failure_flag <= 1'b0;
      drive_enable       <= 1'b0;
      low_side_on        <= 3'h0;
      drive_angle        <= 16'h0;
      drive_magnitude    <= 16'h0;
      current_regulated  <= 1'b0;
    end else begin
      start_q <= run_req;
      if (~run_req) begin
        // Stop: everything off, ready for next start
        state             <= `MSS_ST_IDLE;
        drive_enable      <= 1'b0;
        low_side_on       <= 3'h0;
        drive_magnitude   <= 16'h0;
        current_regulated <= 1'b0;
      end else begin
        case (state)
          `MSS_ST_IDLE: begin
            if (start_edge) begin
              start_failure_flag <= 1'b0;
              cal_count <= 13'h0;
              acc_v     <= 24'h0;
              acc_w     <= 24'h0;
              state <= secondary_motor_control_bits[`MSS_MCBS_SKIP_CAL] ? `MSS_ST_PRECHG
                                                                         : `MSS_ST_CAL;
              pc_total <= 16'h0;
              pc_step  <= 8'h00;
              pc_leg   <= 2'h0;
              pc_on    <= 1'b1;
            end
          end
          `MSS_ST_CAL: begin
            acc_v     <= cal_sum_v;
            acc_w     <= cal_sum_w;
            cal_count <= cal_count + 13'h1;
            if (cal_count == `MSS_CAL_SAMPLES - 13'h1) begin
              offset_v <= cal_sum_v[`MSS_CAL_SHIFT+11:`MSS_CAL_SHIFT];
              offset_w <= cal_sum_w[`MSS_CAL_SHIFT+11:`MSS_CAL_SHIFT];
              state    <= `MSS_ST_PRECHG;
            end
          end
          `MSS_ST_PRECHG: begin
            pc_total <= pc_total + 16'h1;
            pc_step  <= pc_step + 8'h1;
            low_side_on <= pc_on ? (3'h1 << pc_leg) : 3'h0;
            if (pc_on & pc_step >= precharge_pulse_width) begin
              pc_on   <= 1'b0;
              pc_step <= 8'h00;
            end else if (~pc_on & pc_step >= precharge_pulse_delay) begin
              pc_on   <= 1'b1;
              pc_step <= 8'h00;
              pc_leg  <= (pc_leg == 2'h2) ? 2'h0 : pc_leg + 2'h1;
            end
            if (pc_total >= precharge_total_time) begin
              low_side_on <= 3'h0;
              tick        <= 24'h0;
              park_count  <= 10'h0;
              est_freq    <= 32'h0;
              if (diag == `MSS_DIAG_VF)
                state <= `MSS_ST_VF;
              else if (park_duration == 8'h00 && diag != `MSS_DIAG_PARK)
                state <= `MSS_ST_OPEN;
              else
                state <= `MSS_ST_PARK;
            end
          end
          `MSS_ST_PARK: begin
            drive_enable    <= 1'b1;
            drive_magnitude <= {park_current_level, 8'h00};
            drive_angle     <= (park_count < park_quarter) ? {park_angle_first, 8'h00}
                                                           : {park_angle_final, 8'h00};
            angle_acc       <= {park_angle_final, 8'h00};
            tick <= tick + 24'h1;
            if (tick == `MSS_PARK_TICK / 4 - 1) begin
              tick <= 24'h0;
              if (park_count != 10'h3FF)
                park_count <= park_count + 10'h1;
            end
            if (diag != `MSS_DIAG_PARK && park_count >= park_total)
              state <= `MSS_ST_OPEN;
          end
          `MSS_ST_OPEN: begin
            drive_enable      <= 1'b1;
            current_regulated <= 1'b1;
            drive_magnitude   <= {park_current_level, 8'h00};
            est_freq  <= est_freq + {16'h0, open_loop_torque_gain};
            angle_acc <= sequencer_control[`MSS_CTRL_DIR] ? angle_acc - est_freq[31:16]
                                                          : angle_acc + est_freq[31:16];
            drive_angle <= angle_acc;
            fail_timer  <= 24'h0;
            if (est_freq[31:16] >= closed_loop_switch_threshold) begin
              emf_freq <= est_freq[31:16];
              state    <= `MSS_ST_CLOSED;
            end
          end
          // drive depth from back EMF speed and bus
          `MSS_ST_CLOSED: begin
            current_regulated <= 1'b0;
            emf_freq  <= emf_freq + ((emf_freq < speed_setpoint) ? 16'h1 : 16'h0)
                                  - ((emf_freq > speed_setpoint) ? 16'h1 : 16'h0);
            drive_magnitude <= ({4'h0, fb_bus} * {8'h00, emf_freq[15:8]}) >> 4;
            angle_acc <= sequencer_control[`MSS_CTRL_DIR] ? angle_acc - emf_freq
                                                          : angle_acc + emf_freq;
            drive_angle <= angle_acc;
            if (fail_timer != `MSS_PARK_TICK) begin
              fail_timer <= fail_timer + 24'h1;
            end else if (emf_freq < fail_speed_limit || fb_bus == 12'h000) begin
              start_failure_flag <= 1'b1;
              state <= `MSS_ST_FAIL;
            end
          end
          `MSS_ST_VF: begin
            drive_enable    <= 1'b1;
            emf_freq        <= speed_setpoint;
            drive_magnitude <= vf_product[31:16];
            angle_acc       <= angle_acc + emf_freq;
            drive_angle     <= angle_acc;
            if (diag != `MSS_DIAG_VF)
              state <= `MSS_ST_IDLE;
          end
          `MSS_ST_FAIL: begin
            drive_enable    <= 1'b0;
            drive_magnitude <= 16'h0;
          end
          default: state <= `MSS_ST_IDLE;
        endcase
      end
    end
  end

endmodule // mss_motor_startup_sequencer

// ===== testbench/mss_startup_checker.sv
/*
  Port-level assertions of the motor start-up sequencer.
  Assumes binding into the sequencer top with its 250 MHz sys_clk.
*/
`timescale 1ns/1ps
`include "mss_defines.vh"

module mss_startup_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Drive command
  input wire logic        drive_enable,
  input wire logic [2:0]  low_side_on,
  input wire logic        current_regulated
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_lowside_onehot: assert property ($onehot0(low_side_on))
    else $error("more than one low-side switch on");
  a_precharge_idle: assert property (|low_side_on |-> !drive_enable)
    else $error("drive on during pre-charge");
  a_open_drives: assert property (current_regulated |-> drive_enable)
    else $error("current regulation without drive");
  // Quiet outputs leaving reset
  a_reset_quiet: assert property ($fell(sys_rst) |-> !drive_enable && low_side_on == 3'h0)
    else $error("outputs active after reset");
  // Write answer held and bounded
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_write_answer: assert property ($rose(s_axi_awready) |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  // Read answer held and timed
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_unmapped_read: assert property (s_axi_arready && s_axi_araddr > 8'h30 |=>
    s_axi_rresp == `MSS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");

  // Main scenarios reached
  c_precharge: cover property (|low_side_on);
  c_open_loop: cover property ($rose(current_regulated));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == `MSS_RESP_SLVERR);
endmodule // mss_startup_checker

bind mss_motor_startup_sequencer mss_startup_checker mss_startup_checker_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .drive_enable(drive_enable),
  .low_side_on(low_side_on), .current_regulated(current_regulated));

// ===== testbench/mss_power_stage_model.sv
/*
  Behavioural power stage and motor: phase current feedback and bus voltage.
  Assumes the sequencer's drive outputs on the same sys_clk.
*/
`timescale 1ns/1ps

module mss_power_stage_model #(
  parameter BUS_LEVEL = 12'hA00
) (
  // Clock
  input  wire        sys_clk,
  // Drive command
  input  wire        drive_enable,
  input  wire [15:0] drive_magnitude,
  // Resting sensor offsets chosen by the bench
  input  wire [11:0] idle_v,
  input  wire [11:0] idle_w,
  // Feedback to the sequencer
  output reg  [11:0] fb_v,
  output reg  [11:0] fb_w,
  output reg  [11:0] bus_v
);
  // Current follows the command; a stopped motor leaves only the offset
  always @(posedge sys_clk) begin
    fb_v  <= drive_enable ? idle_v + {2'h0, drive_magnitude[15:6]} : idle_v;
    fb_w  <= drive_enable ? idle_w - {2'h0, drive_magnitude[15:6]} : idle_w;
    bus_v <= BUS_LEVEL;
  end
endmodule // mss_power_stage_model

// ===== testbench/tb.sv
/*
  Self-checking bench of the motor start-up sequencer.
  Assumes the power stage model beside it and AXI4-Lite access only.
*/
`timescale 1ns/1ps
`include "mss_defines.vh"

module tb;
  // Clock, reset and bus master signals
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [11:0] idle_v = 12'h000, idle_w = 12'h000;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [11:0] fb_v, fb_w, bus_v, offset_v, offset_w;
  wire        drive_enable, current_regulated;
  wire [2:0]  low_side_on;
  wire [15:0] drive_angle, drive_magnitude;
  // Bench state
  integer     n_fail, n_compared, i, lead_ls, lead_open, n_open;
  reg  [31:0] seed = 32'h701A, rd_data = 32'h0;
  reg  [1:0]  rd_resp, wr_resp;
  reg  [2:0]  seen_ls;
  reg         run = 1'b0;
  reg  [15:0] a1, d1;

  always #2 sys_clk = ~sys_clk;

  mss_motor_startup_sequencer mss_motor_startup_sequencer_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .phase_v_current_feedback(fb_v),
    .phase_w_current_feedback(fb_w), .filtered_bus_voltage(bus_v),
    .drive_enable(drive_enable), .low_side_on(low_side_on), .drive_angle(drive_angle),
    .drive_magnitude(drive_magnitude), .current_regulated(current_regulated),
    .offset_v(offset_v), .offset_w(offset_w), .corrected_v(), .corrected_w());

  mss_power_stage_model mss_power_stage_model_inst (
    .sys_clk(sys_clk), .drive_enable(drive_enable), .drive_magnitude(drive_magnitude),
    .idle_v(idle_v), .idle_w(idle_w), .fb_v(fb_v), .fb_w(fb_w), .bus_v(bus_v));

  // Start-up monitor: cycles to first pre-charge, to open loop, open-loop length
  always @(posedge sys_clk) begin
    if (!run) begin
      lead_ls <= 0;
      lead_open <= 0;
      n_open <= 0;
      seen_ls <= 3'h0;
    end else begin
      seen_ls <= seen_ls | low_side_on;
      if (seen_ls == 3'h0 && low_side_on == 3'h0) lead_ls <= lead_ls + 1;
      if (n_open == 0 && !current_regulated) lead_open <= lead_open + 1;
      if (current_regulated) n_open <= n_open + 1;
    end
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task report_and_stop;
    begin
      if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task timeout;
    begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  endtask

  // Write: address and data offered together, each released when taken
  task axi_wr(input [7:0] a, input [31:0] d);
    reg done;
    integer n;
    begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge sys_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          wr_resp = s_axi_bresp;
          s_axi_bready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done) timeout;
    end
  endtask

  // Read: address held until taken, data taken with rvalid
  task axi_rd(input [7:0] a);
    reg done;
    integer n;
    begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge sys_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          rd_data = s_axi_rdata;
          rd_resp = s_axi_rresp;
          s_axi_rready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done) timeout;
    end
  endtask

  task wait_state(input [2:0] st);
    integer n;
    begin
      rd_data = 32'h0;
      for (n = 0; n < 3000 && rd_data[2:0] !== st; n = n + 1) axi_rd(`MSS_OFS_STATUS);
      if (rd_data[2:0] !== st) timeout;
    end
  endtask

  task cfg(input [31:0] park, input [31:0] pre, input [31:0] mcb, input [31:0] mcbs);
    begin
      axi_wr(`MSS_OFS_PARK, park);
      axi_wr(`MSS_OFS_PRECHG, pre);
      axi_wr(`MSS_OFS_MCB, mcb);
      axi_wr(`MSS_OFS_MCB_S, mcbs);
    end
  endtask

  task start(input [31:0] c);
    begin
      run <= 1'b1;
      axi_wr(`MSS_OFS_CTRL, c);
    end
  endtask

  // Stop takes effect at the edge after the write is taken
  task stop;
    begin
      axi_wr(`MSS_OFS_CTRL, 32'h0);
      @(negedge sys_clk);
      chk({31'h0, drive_enable}, 32'h0);
      run <= 1'b0;
    end
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    timeout;
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    idle_v <= seed[11:0];
    idle_w <= seed[27:16];
    // Idle after reset, unmapped places refused
    axi_rd(`MSS_OFS_STATUS);
    chk(rd_data, 32'h0);
    axi_rd(8'h3C);
    chk({rd_data[29:0], rd_resp}, {30'h0, `MSS_RESP_SLVERR});
    axi_wr(8'h34, seed);
    chk({30'h0, wr_resp}, {30'h0, `MSS_RESP_SLVERR});
    for (i = 0; i < 12; i = i + 1) begin
      seed = lfsr(seed);
      axi_wr(`MSS_OFS_PARK + 8'h04 * (i % 2) + 8'h10 * (i % 3 == 2), seed);
      axi_rd(`MSS_OFS_PARK + 8'h04 * (i % 2) + 8'h10 * (i % 3 == 2));
      chk(rd_data, (i % 3 == 2 && i % 2 == 0) ? {16'h0, seed[15:0]} : seed);
    end
    axi_wr(`MSS_OFS_KTORQ, 32'h0000_FFFF);
    axi_wr(`MSS_OFS_CLOSED_LOOP_SWITCH_THRESHOLD, 32'h0000_0014);
    axi_wr(`MSS_OFS_SPEED, 32'h0000_1000);
    axi_wr(`MSS_OFS_VF, 32'h0000_0100);
    cfg(32'h0, 32'h001E_0204, 32'h0, 32'h0);
    start(32'h1);
    wait_state(`MSS_ST_CLOSED);
    chk({31'h0, lead_ls >= 4096}, 32'h1);
    chk({29'h0, seen_ls}, 32'h7);
    chk({31'h0, lead_open > lead_ls}, 32'h1);
    chk({31'h0, n_open >= 19 && n_open <= 22}, 32'h1);
    chk({offset_w, 4'h0, offset_v}, {idle_w, 4'h0, idle_v});
    stop;
    // new settings, no calibration or pre-charge
    cfg(32'h0, 32'h0000_0204, 32'h0, 32'h40);
    start(32'h1);
    wait_state(`MSS_ST_CLOSED);
    chk({31'h0, lead_open < 4096}, 32'h1);
    chk({29'h0, seen_ls}, 32'h0);
    stop;
    seed = lfsr(seed);
    cfg({8'h01, seed[23:0]}, 32'h0, 32'h1, 32'h40);
    start(32'h1);
    wait_state(`MSS_ST_PARK);
    repeat (2000) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({16'h0, drive_angle[15:8], 8'h00}, {16'h0, seed[7:0], 8'h00});
    chk({16'h0, drive_magnitude}, {16'h0, seed[23:16], 8'h00});
    chk({30'h0, drive_enable, current_regulated}, 32'h2);
    stop;
    // V/Hz turns the same way for either direction bit
    cfg(32'h0, 32'h0, 32'h2, 32'h40);
    for (i = 0; i < 2; i = i + 1) begin
      start(32'h3 - 32'h2 * i);
      wait_state(`MSS_ST_VF);
      a1 = drive_angle;
      repeat (200) @(posedge sys_clk);
      if (i == 1) chk({31'h0, d1[15]}, {31'h0, drive_angle[15] ^ a1[15]});
      d1 = drive_angle - a1;
      chk({31'h0, drive_enable}, 32'h1);
      stop;
    end
    report_and_stop;
  end
endmodule // tb
